// ==== include/smb_pkg.sv ====
// shared constants and state types for both ends of the two-wire link
// assumes a single 100 MHz system clock on each end
package smb_pkg;

	// clock and bit timing
	localparam int SMB_CLK_NS = 10;
	// half an scl period of the generated clock
	localparam int SMB_HALF_NS = 5000;
	localparam int SMB_HALF_CYC = (SMB_HALF_NS + SMB_CLK_NS - 1) / SMB_CLK_NS;
	localparam logic [8:0] SMB_HALF_LAST = 9'(SMB_HALF_CYC - 1);

	// special function register map of the device end
	localparam logic [7:0] SMB_CTRL_ADDR = 8'hC0;
	localparam logic [7:0] SMB_DATA_ADDR = 8'hC2;
	localparam logic [7:0] SMB_SFR_PAGE = 8'h00;
	localparam logic [7:0] SMB_CTRL_RESET = 8'h00;
	localparam logic [7:0] SMB_DATA_RESET = 8'h00;

	// control register bit positions
	localparam int SMB_B_MASTER = 7;
	localparam int SMB_B_TRANSMIT_DIRECTION_FLAG = 6;
	localparam int SMB_B_STA = 5;
	localparam int SMB_B_STO = 4;
	localparam int SMB_B_ACK_REQUEST = 3;
	localparam int SMB_B_LOST = 2;
	localparam int SMB_B_ACK = 1;
	localparam int SMB_B_SI = 0;

	// far end register byte addresses on the avalon slave
	localparam logic [3:0] SMB_F_CMD = 4'h0;
	localparam logic [3:0] SMB_F_TX = 4'h4;
	localparam logic [3:0] SMB_F_STAT = 4'h8;

	// far end command bits
	localparam int SMB_C_START = 0;
	localparam int SMB_C_STOP = 1;
	localparam int SMB_C_WRITE = 2;
	localparam int SMB_C_READ = 3;
	localparam int SMB_C_ACK = 4;

	// far end status bits
	localparam int SMB_S_BUSY = 0;
	localparam int SMB_S_ACK = 1;
	localparam int SMB_S_LOST = 2;
	localparam int SMB_S_RX = 8;

	// bit and frame counts
	localparam logic [3:0] SMB_ACK_BIT = 4'h8;
	localparam logic [3:0] SMB_ACK_END = 4'h9;

	typedef enum logic [2:0] {
		SMB_ST_IDLE = 3'h0,
		SMB_ST_START = 3'h1,
		SMB_ST_XFER = 3'h3,
		SMB_ST_STOP = 3'h2
	} smb_dev_state_t;

	typedef enum logic [2:0] {
		SMB_FS_IDLE = 3'h0,
		SMB_FS_START = 3'h1,
		SMB_FS_BIT = 3'h3,
		SMB_FS_STOP = 3'h2
	} smb_far_state_t;

endpackage

// ==== include/smb_link_if.sv ====
// open-drain scl and sda between the device end and the far end
// each end pulls a line low by raising its enable; lines idle high
`timescale 1ns/1ps
interface smb_link_if;
	logic devSclOe;
	logic devSdaOe;
	logic farSclOe;
	logic farSdaOe;
	logic scl;
	logic sda;

	// wired-and with pull-ups
	assign scl = ~(devSclOe | farSclOe);
	assign sda = ~(devSdaOe | farSdaOe);

	modport dev (output devSclOe, output devSdaOe, input scl, input sda);
	modport far (output farSclOe, output farSdaOe, input scl, input sda);
endinterface

// ==== hw/smb_ctrl_dev.sv ====
// device end: control/status register, data register and byte engine
// assumes an sfr port with byte and bit writes, one clock, pins unsynced
// How it works
// - bit 7 reads one when master
// - bit 6 reads one when transmitting
// - master set on start, cleared stop/lost
// - direction follows start, detect, data writes
// - bit 5 shows start; writing requests start
// - start plus address sets bit 5
// - bit 4 requests stop after ack
// - stop as slave or lost sets bit 4
// - ack request set per received byte
// - four arbitration loss causes set bit 2
// - clearing interrupt flag clears arbitration loss
// - bit 1 captures or supplies acknowledge
// - interrupt flag set on bus events
// - scl held low while flag set during a transfer
// - write zero resumes, write one forces
// - register at c0 page 0, reset zero
// - start and stop together: stop then start
// - no acknowledge written means nack sent
// - nacked address ignored until next start
//
`timescale 1ns/1ps
module smb_ctrl_dev
	import smb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	smb_link_if.dev link,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrPage,
	input wire logic sfrWr,
	input wire logic sfrBitWr,
	input wire logic [2:0] sfrBitSel,
	input wire logic [7:0] sfrWrData,
	output logic [7:0] sfrRdData
);
	smb_dev_state_t state;
	logic [1:0] sclSync, sdaSync, ph;
	logic sclP, sdaP, sclS, sdaS, tick, busy;
	logic [8:0] divCnt;
	logic [3:0] cnt;
	logic [7:0] shReg, wrMask, wrVal;
	logic genScl, genSda, master, transmit_direction_flag, slaveAct, addrPh, bnd, ackPh;
	logic outBit, begin_condition_flag, end_condition_flag, ack_request, arbitration_lost, ack, si, ackWr, datWritten;
	logic ctrlHit, datHit, ctlWr, datWr, swSta, swSto, swAck, swSi;
	logic startDet, stopDet, sclRise, sclFall, ownCond, inXfer, ackSend;
	logic evRise, evFall, evByteRx, evAckEnd, evTxDone, evAckIn, evAddr;
	logic evArbSda, evArbRs, evArbStop, evArbScl, evArb, evStopRx;
	logic evStartGen, evStopGen, evBnd, siSet, siClr;
	logic staReq;

	// pins pass two flops; the second stage and a third flop, used for edge detection, feed logic
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			sclP <= 1'b1;
			sdaP <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], link.scl};
			sdaSync <= {sdaSync[0], link.sda};
			sclP <= sclSync[1];
			sdaP <= sdaSync[1];
		end
	end

	assign sclS = sclSync[1];
	assign sdaS = sdaSync[1];
	assign sclRise = sclS & ~sclP;
	assign sclFall = ~sclS & sclP;
	// sda edges while scl stays high mark start and stop
	assign startDet = sclS & sclP & sdaP & ~sdaS;
	assign stopDet = sclS & sclP & ~sdaP & sdaS;

	// half-bit enable for the generated clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt <= 9'h000;
		end else if (divCnt == SMB_HALF_LAST) begin
			divCnt <= 9'h000;
		end else begin
			divCnt <= divCnt + 9'h001;
		end
	end
	assign tick = (divCnt == SMB_HALF_LAST);

	always_comb begin
		ctrlHit = (sfrPage == SMB_SFR_PAGE) && (sfrAddr == SMB_CTRL_ADDR);
		datHit = (sfrPage == SMB_SFR_PAGE) && (sfrAddr == SMB_DATA_ADDR);
		wrMask = sfrBitWr ? (8'h01 << sfrBitSel) : 8'hFF;
		wrVal = sfrBitWr ? {8{sfrWrData[0]}} : sfrWrData;
	end
	assign ctlWr = (sfrWr | sfrBitWr) & ctrlHit;
	assign datWr = (sfrWr | sfrBitWr) & datHit;
	// only writable bits decode a write
	assign swSta = ctlWr & wrMask[SMB_B_STA];
	assign swSto = ctlWr & wrMask[SMB_B_STO];
	assign swAck = ctlWr & wrMask[SMB_B_ACK];
	assign swSi = ctlWr & wrMask[SMB_B_SI];

	// bus events seen by the engine
	assign ownCond = (state == SMB_ST_START) || (state == SMB_ST_STOP);
	assign inXfer = (state == SMB_ST_XFER);
	assign evRise = inXfer & sclRise;
	assign evFall = inXfer & sclFall;
	assign evByteRx = evFall & (cnt == SMB_ACK_BIT) & ~transmit_direction_flag;
	assign evAckEnd = evFall & (cnt == SMB_ACK_END);
	assign evTxDone = evAckEnd & transmit_direction_flag;
	assign evAckIn = evRise & (cnt == SMB_ACK_BIT) & transmit_direction_flag;
	assign evAddr = evByteRx & addrPh;
	// ack only if software wrote it this byte
	assign ackSend = ack & ackWr;
	assign evArbSda = evRise & (cnt < SMB_ACK_BIT) & transmit_direction_flag & outBit & ~sdaS;
	assign evArbRs = startDet & master & ~ownCond & ~begin_condition_flag;
	assign evArbScl = ownCond & tick & (ph == 2'h1) & ~sclS;
	assign evArbStop = stopDet & master & ~ownCond;
	assign evArb = evArbSda | evArbRs | evArbScl | evArbStop;
	assign evStopRx = stopDet & slaveAct & inXfer;
	assign evStartGen = (state == SMB_ST_START) & tick & (ph == 2'h2);
	assign evStopGen = (state == SMB_ST_STOP) & tick & (ph == 2'h2);
	assign evBnd = inXfer & bnd & ~si;
	assign siSet = evStartGen | evArb | evTxDone | evByteRx | evStopRx;
	assign siClr = swSi & ~wrVal[SMB_B_SI] & ~siSet;

	// bus busy between a start and a stop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
		end else if (startDet) begin
			busy <= 1'b1;
		end else if (stopDet) begin
			busy <= 1'b0;
		end
	end

	// software flags; hardware set wins over a same-cycle clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			begin_condition_flag <= 1'b0;
			end_condition_flag <= 1'b0;
			ack_request <= 1'b0;
			arbitration_lost <= 1'b0;
			ack <= 1'b0;
			si <= 1'b0;
			ackWr <= 1'b0;
			datWritten <= 1'b0;
			staReq <= 1'b0;
		end else begin
			// only software asks for a start; a heard one does not
			if (evAddr) staReq <= 1'b0;
			else if (swSta) staReq <= wrVal[SMB_B_STA];
			// set on address, cleared only by a software write
			if (evAddr) begin_condition_flag <= 1'b1;
			else if (swSta) begin_condition_flag <= wrVal[SMB_B_STA];
			// stop seen as slave or on loss
			if (evStopRx | evArbStop) end_condition_flag <= 1'b1;
			else if (evStopGen) end_condition_flag <= 1'b0;
			else if (swSto) end_condition_flag <= wrVal[SMB_B_STO];
			if (evByteRx) ack_request <= 1'b1;
			else if (evAckEnd) ack_request <= 1'b0;
			if (evArb) arbitration_lost <= 1'b1;
			else if (siClr) arbitration_lost <= 1'b0;
			// capture incoming ack or take software value
			if (evAckIn) ack <= ~sdaS;
			else if (swAck) ack <= wrVal[SMB_B_ACK];
			if (swAck) ackWr <= 1'b1;
			else if (evAckEnd) ackWr <= 1'b0;
			if (siSet) si <= 1'b1;
			else if (swSi) si <= wrVal[SMB_B_SI];
			if (datWr) datWritten <= 1'b1;
			else if (evBnd) datWritten <= 1'b0;
		end
	end

	// data register: software writes or bus shifts msb first
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shReg <= SMB_DATA_RESET;
		end else if (datWr) begin
			shReg <= (shReg & ~wrMask) | (wrVal & wrMask);
		end else if (evRise && cnt < SMB_ACK_BIT) begin
			shReg <= {shReg[6:0], sdaS};
		end
	end

	// byte engine, condition generator and role tracking
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SMB_ST_IDLE;
			ph <= 2'h0;
			cnt <= 4'h0;
			genScl <= 1'b1;
			genSda <= 1'b1;
			master <= 1'b0;
			transmit_direction_flag <= 1'b0;
			slaveAct <= 1'b0;
			addrPh <= 1'b0;
			bnd <= 1'b0;
			ackPh <= 1'b0;
			outBit <= 1'b1;
		end else if (startDet && !ownCond) begin
			// foreign start: listen as slave receiver
			// a new start ends any ignoring
			state <= SMB_ST_XFER;
			master <= 1'b0;
			transmit_direction_flag <= 1'b0;
			slaveAct <= 1'b1;
			addrPh <= 1'b1;
			cnt <= 4'h0;
			bnd <= 1'b0;
			ackPh <= 1'b0;
			genScl <= 1'b1;
			genSda <= 1'b1;
		end else if (evArbSda || evArbScl || (stopDet && inXfer)) begin
			// losing arbitration drops the master role
			state <= SMB_ST_IDLE;
			master <= 1'b0;
			transmit_direction_flag <= 1'b0;
			slaveAct <= 1'b0;
			genScl <= 1'b1;
			genSda <= 1'b1;
		end else begin
			case (state)
				SMB_ST_IDLE: begin
					genScl <= 1'b1;
					genSda <= 1'b1;
					bnd <= 1'b0;
					// start when the bus is free
					if (staReq && !busy) begin
						state <= SMB_ST_START;
						ph <= 2'h0;
					end
				end
				SMB_ST_START: if (tick) begin
					if (ph == 2'h0) begin
						genScl <= 1'b1;
						ph <= 2'h1;
					end else if (ph == 2'h1) begin
						genSda <= 1'b0;
						ph <= 2'h2;
					end else begin
						genScl <= 1'b0;
						master <= 1'b1;
						transmit_direction_flag <= 1'b1;
						slaveAct <= 1'b0;
						state <= SMB_ST_XFER;
						cnt <= 4'h0;
						ackPh <= 1'b0;
						bnd <= 1'b1;
					end
				end
				SMB_ST_STOP: if (tick) begin
					if (ph == 2'h0) begin
						genScl <= 1'b1;
						ph <= 2'h1;
					end else if (ph == 2'h1) begin
						genSda <= 1'b1;
						ph <= 2'h2;
					end else begin
						master <= 1'b0;
						ph <= 2'h0;
						// a pending start follows the stop
						state <= begin_condition_flag ? SMB_ST_START : SMB_ST_IDLE;
					end
				end
				default: begin
					// no clock while the flag is set
					if (master && tick && !si && !bnd) begin
						if (!genScl) genScl <= 1'b1;
						else if (sclS) genScl <= 1'b0;
					end
					if (sclRise) cnt <= cnt + 4'h1;
					if (sclFall) begin
						if (cnt == SMB_ACK_BIT) begin
							ackPh <= 1'b1;
						end else if (cnt == SMB_ACK_END) begin
							ackPh <= 1'b0;
							cnt <= 4'h0;
							bnd <= 1'b1;
							addrPh <= 1'b0;
							if (addrPh && !ackSend) begin
								slaveAct <= 1'b0;
								state <= SMB_ST_IDLE;
							end
						end else begin
							outBit <= shReg[7];
						end
					end
					if (bnd && !si) begin
						bnd <= 1'b0;
						outBit <= shReg[7];
						ph <= 2'h0;
						if (master && end_condition_flag) begin
							state <= SMB_ST_STOP;
							genSda <= 1'b0;
						end else if (master && begin_condition_flag) begin
							state <= SMB_ST_START;
							genSda <= 1'b1;
						end else begin
							transmit_direction_flag <= datWritten;
						end
					end
				end
			endcase
		end
	end

	// open-drain drive; the sda drive moves while scl is high only for start and stop
	always_comb begin
		link.devSclOe = 1'b0;
		link.devSdaOe = 1'b0;
		if (ownCond) begin
			link.devSclOe = ~genScl;
			link.devSdaOe = ~genSda;
		end else if (inXfer) begin
			// hold scl low to stall the bus
			link.devSclOe = ~genScl | si;
			link.devSdaOe = ackPh ? (~transmit_direction_flag & ackSend) : (transmit_direction_flag & ~outBit);
		end
	end

	// read-back, one cycle after the address
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sfrRdData <= SMB_CTRL_RESET;
		end else if (ctrlHit) begin
			sfrRdData <= {master, transmit_direction_flag, begin_condition_flag, end_condition_flag, ack_request, arbitration_lost, ack, si};
		end else if (datHit) begin
			sfrRdData <= shReg;
		end else begin
			sfrRdData <= 8'h00;
		end
	end
endmodule

// ==== hw/smb_far_master.sv ====
// far end: a bus master driven by software over avalon-mm
// assumes one clock; the link pins are resynchronised here
`timescale 1ns/1ps
module smb_far_master
	import smb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	smb_link_if.far link,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest
);
	smb_far_state_t state;
	logic [1:0] sclSync, sdaSync, ph;
	logic [8:0] divCnt;
	logic [3:0] idx;
	logic [4:0] pend;
	logic [7:0] txByte, rxByte;
	logic sclS, sdaS, tick, busy, ackIn, lost, sclDrv, sdaDrv, ackd;
	logic req, stall, accept, txBit;

	// two-flop synchronisers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
		end else begin
			sclSync <= {sclSync[0], link.scl};
			sdaSync <= {sdaSync[0], link.sda};
		end
	end
	assign sclS = sclSync[1];
	assign sdaS = sdaSync[1];

	// phase enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt <= 9'h000;
		end else if (divCnt == SMB_HALF_LAST) begin
			divCnt <= 9'h000;
		end else begin
			divCnt <= divCnt + 9'h001;
		end
	end
	assign tick = (divCnt == SMB_HALF_LAST);

	// commands wait while a sequence runs, stalling the bus master
	assign busy = (|pend[3:0]) | (state != SMB_FS_IDLE);
	assign req = read | write;
	assign stall = write & (address == SMB_F_CMD) & busy;
	assign waitrequest = req & (~ackd | stall);
	assign accept = req & ~waitrequest;
	assign txBit = txByte[3'(4'h7 - idx)];

	// first cycle of each access always waits
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ackd <= 1'b0;
		end else begin
			ackd <= req & ~(ackd & ~stall);
		end
	end

	// read data captured in the waiting cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readdata <= 32'h0000_0000;
		end else if (read && !ackd) begin
			if (address == SMB_F_CMD) begin
				readdata <= {27'h0, pend};
			end else if (address == SMB_F_TX) begin
				readdata <= {24'h0, txByte};
			end else if (address == SMB_F_STAT) begin
				readdata <= {16'h0, rxByte, 5'h0, lost, ackIn, busy};
			end else begin
				readdata <= 32'h0000_0000;
			end
		end
	end

	// transmit byte register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txByte <= 8'h00;
		end else if (accept && write && address == SMB_F_TX) begin
			txByte <= writedata[7:0];
		end
	end

	// sequencer: start, then write or read, then stop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SMB_FS_IDLE;
			pend <= 5'h00;
			ph <= 2'h0;
			idx <= 4'h0;
			sclDrv <= 1'b0;
			sdaDrv <= 1'b0;
			rxByte <= 8'h00;
			ackIn <= 1'b0;
			lost <= 1'b0;
		end else if (accept && write && address == SMB_F_CMD) begin
			pend <= writedata[4:0];
			lost <= 1'b0;
		end else begin
			case (state)
				SMB_FS_IDLE: begin
					ph <= 2'h0;
					idx <= 4'h0;
					if (pend[SMB_C_START]) state <= SMB_FS_START;
					else if (pend[SMB_C_WRITE] | pend[SMB_C_READ]) state <= SMB_FS_BIT;
					else if (pend[SMB_C_STOP]) state <= SMB_FS_STOP;
				end
				SMB_FS_START: if (tick) begin
					if (ph == 2'h0) begin
						sdaDrv <= 1'b0;
						ph <= 2'h1;
					end else if (ph == 2'h1) begin
						sclDrv <= 1'b0;
						ph <= 2'h2;
					end else if (ph == 2'h2) begin
						// wait out a stretched clock
						if (sclS) begin
							sdaDrv <= 1'b1;
							ph <= 2'h3;
						end
					end else begin
						sclDrv <= 1'b1;
						pend[SMB_C_START] <= 1'b0;
						state <= SMB_FS_IDLE;
					end
				end
				SMB_FS_BIT: if (tick) begin
					if (ph == 2'h0) begin
						sclDrv <= 1'b1;
						if (idx < SMB_ACK_BIT) begin
							sdaDrv <= pend[SMB_C_WRITE] & ~txBit;
						end else begin
							sdaDrv <= pend[SMB_C_READ] & pend[SMB_C_ACK];
						end
						ph <= 2'h1;
					end else if (ph == 2'h1) begin
						sclDrv <= 1'b0;
						ph <= 2'h2;
					end else if (ph == 2'h2) begin
						if (sclS) begin
							ph <= 2'h3;
							if (idx < SMB_ACK_BIT && pend[SMB_C_READ]) begin
								rxByte <= {rxByte[6:0], sdaS};
							end
							if (idx == SMB_ACK_BIT && pend[SMB_C_WRITE]) begin
								ackIn <= ~sdaS;
							end
							// lost the bus while sending a one
							if (idx < SMB_ACK_BIT && pend[SMB_C_WRITE] && txBit && !sdaS) begin
								lost <= 1'b1;
								pend <= 5'h00;
								sdaDrv <= 1'b0;
								state <= SMB_FS_IDLE;
							end
						end
					end else begin
						sclDrv <= 1'b1;
						ph <= 2'h0;
						idx <= idx + 4'h1;
						if (idx == SMB_ACK_BIT) begin
							pend[SMB_C_WRITE] <= 1'b0;
							pend[SMB_C_READ] <= 1'b0;
							state <= SMB_FS_IDLE;
						end
					end
				end
				default: if (tick) begin
					if (ph == 2'h0) begin
						sclDrv <= 1'b1;
						sdaDrv <= 1'b1;
						ph <= 2'h1;
					end else if (ph == 2'h1) begin
						sclDrv <= 1'b0;
						ph <= 2'h2;
					end else if (ph == 2'h2) begin
						if (sclS) begin
							sdaDrv <= 1'b0;
							ph <= 2'h3;
						end
					end else begin
						pend[SMB_C_STOP] <= 1'b0;
						state <= SMB_FS_IDLE;
					end
				end
			endcase
		end
	end

	assign link.farSclOe = sclDrv;
	assign link.farSdaOe = sdaDrv;
endmodule

// ==== tb/smb_link_checker.sv ====
// checker for the open-drain link between the two ends
// assumes it watches the link signals of one interface, one clock domain
`timescale 1ns/1ps
module smb_link_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic devSclOe,
	input wire logic devSdaOe,
	input wire logic farSclOe,
	input wire logic farSdaOe,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// cycles from a start on a high clock line to the first clock pull;
	// counters stand in for long delay ranges, which slow the tools
	logic devSdaOeQ, farSdaOeQ;
	logic [11:0] devWait, farWait;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			devSdaOeQ <= 1'b0;
			farSdaOeQ <= 1'b0;
			devWait <= 12'h000;
			farWait <= 12'h000;
		end else begin
			devSdaOeQ <= devSdaOe;
			farSdaOeQ <= farSdaOe;
			if (devSclOe) devWait <= 12'h000;
			else if (devSdaOe && !devSdaOeQ && scl) devWait <= 12'h001;
			else if (devWait != 12'h000) devWait <= devWait + 12'h001;
			if (farSclOe) farWait <= 12'h000;
			else if (farSdaOe && !farSdaOeQ && scl) farWait <= 12'h001;
			else if (farWait != 12'h000) farWait <= farWait + 12'h001;
		end
	end

	// lines are the wired-and of both pull-downs
	a_scl_wired_and: assert property (scl == !(devSclOe | farSclOe))
		else $error("scl does not follow the pull-downs");
	a_sda_wired_and: assert property (sda == !(devSdaOe | farSdaOe))
		else $error("sda does not follow the pull-downs");
	// device start only on a free data line, clock follows within 1100 cycles
	a_dev_start_free: assert property ($rose(devSdaOe) && scl |-> $past(sda))
		else $error("device start on a busy data line");
	a_dev_start_clocks: assert property (devWait <= 12'h44C)
		else $error("device start not followed by a clock pull");
	// after a stop the clock line is left alone for a while
	a_dev_stop_release: assert property (
		$fell(devSdaOe) && scl |=> !devSclOe [*8])
		else $error("device pulls scl right after its stop");
	// a clock low phase is never a glitch
	a_dev_scl_low_min: assert property ($rose(devSclOe) |=> devSclOe [*8])
		else $error("device scl low phase too short");
	a_far_start_clocks: assert property (farWait <= 12'h834)
		else $error("far start not followed by a clock pull");
	a_far_stop_release: assert property (
		$fell(farSdaOe) && scl |=> !farSclOe [*8])
		else $error("far end pulls scl right after its stop");
	a_far_scl_low_min: assert property ($rose(farSclOe) |=> farSclOe [*8])
		else $error("far scl low phase too short");

	// main scenarios
	c_dev_start: cover property ($rose(devSdaOe) && scl);
	c_dev_stop: cover property ($fell(devSdaOe) && scl);
	c_far_start: cover property ($rose(farSdaOe) && scl);
endmodule

// ==== tb/testbench.sv ====
// self-checking bench: device end and far master joined by the link
// assumes package and interface compiled first; 100 MHz clock
`timescale 1ns/1ps
module testbench
	import smb_pkg::*;
;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic [7:0] sfrAddr = SMB_CTRL_ADDR;
	logic [7:0] sfrPage = SMB_SFR_PAGE;
	logic sfrWr = 1'h0;
	logic sfrBitWr = 1'h0;
	logic [2:0] sfrBitSel = 3'h0;
	logic [7:0] sfrWrData = 8'h00;
	logic [7:0] sfrRdData;
	logic [3:0] address = 4'h0;
	logic read = 1'h0;
	logic write = 1'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [31:0] q;
	int errors = 0;
	int comparisons = 0;

	smb_link_if link ();
	smb_ctrl_dev smb_ctrl_dev_i (.clk(clk), .rst_b(rst_b), .link(link),
		.sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWr(sfrWr),
		.sfrBitWr(sfrBitWr), .sfrBitSel(sfrBitSel), .sfrWrData(sfrWrData),
		.sfrRdData(sfrRdData));
	smb_far_master smb_far_master_i (.clk(clk), .rst_b(rst_b), .link(link),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest));
	smb_link_checker smb_link_checker_i (.clk(clk), .rst_b(rst_b),
		.devSclOe(link.devSclOe), .devSdaOe(link.devSdaOe),
		.farSclOe(link.farSclOe), .farSdaOe(link.farSdaOe),
		.scl(link.scl), .sda(link.sda));

	// free-running system clock
	always #5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// a spent wait bound counts as a mismatch and ends the run
	task automatic giveUp();
		errors++;
		print_verdict();
	endtask

	// byte write when bw is low, single bit write otherwise
	task automatic sfrPut(input logic [7:0] a, input logic bw,
		input logic [2:0] sel, input logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrPage <= SMB_SFR_PAGE;
		sfrWr <= !bw;
		sfrBitWr <= bw;
		sfrBitSel <= sel;
		sfrWrData <= d;
		@(posedge clk);
		sfrWr <= 1'h0;
		sfrBitWr <= 1'h0;
	endtask

	task automatic setBit(input int sel, input logic v);
		sfrPut(SMB_CTRL_ADDR, 1'h1, 3'(sel), {7'h00, v});
	endtask

	// read data is registered, so let two edges pass first
	task automatic sfrGet(input logic [7:0] a, input logic [7:0] p,
		output logic [7:0] v);
		@(posedge clk);
		sfrAddr <= a;
		sfrPage <= p;
		repeat (2) @(posedge clk);
		@(negedge clk);
		v = sfrRdData;
	endtask

	task automatic waitReg(input logic [7:0] mask, input logic [7:0] val);
		int n;
		@(posedge clk);
		sfrAddr <= SMB_CTRL_ADDR;
		sfrPage <= SMB_SFR_PAGE;
		repeat (3) @(posedge clk);
		for (n = 0; n < 40000 && (sfrRdData & mask) !== val; n++)
			@(negedge clk);
		if (n == 40000) giveUp();
	endtask

	// waitrequest and read data are taken at the rising edge itself
	task automatic avAcc(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (waitrequest === 1'h0) break;
		end
		if (n == 100) giveUp();
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
	endtask

	task automatic farIdle();
		int n;
		for (n = 0; n < 30000; n++) begin
			avAcc(1'h0, SMB_F_STAT, 32'h0);
			if (q[SMB_S_BUSY] === 1'h0) break;
		end
		if (n == 30000) giveUp();
	endtask

	initial begin
		logic [7:0] v;
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		// reset values, decoding and read-only bits
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v, SMB_CTRL_RESET);
		sfrGet(SMB_DATA_ADDR, SMB_SFR_PAGE, v); check(v, SMB_DATA_RESET);
		avAcc(1'h0, 4'hC, 32'h0); check(q, 32'h0);
		sfrPut(SMB_CTRL_ADDR, 1'h0, 3'h0, 8'hCD);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v, 8'h01);
		sfrGet(SMB_CTRL_ADDR, 8'h01, v); check(v, 8'h00);
		setBit(SMB_B_SI, 1'h0);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v, 8'h00);
		// device as master: start, unanswered byte, stop then start, stop
		setBit(SMB_B_STA, 1'h1);
		waitReg(8'h01, 8'h01);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v, 8'hE1);
		check(link.scl, 1'h0);
		setBit(SMB_B_STA, 1'h0);
		sfrPut(SMB_DATA_ADDR, 1'h0, 3'h0, 8'hA5);
		setBit(SMB_B_SI, 1'h0);
		waitReg(8'h01, 8'h01);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v, 8'hC1);
		setBit(SMB_B_STO, 1'h1);
		setBit(SMB_B_STA, 1'h1);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v, 8'hF1);
		setBit(SMB_B_SI, 1'h0);
		waitReg(8'h11, 8'h01);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v, 8'hE1);
		setBit(SMB_B_STA, 1'h0);
		setBit(SMB_B_STO, 1'h1);
		setBit(SMB_B_SI, 1'h0);
		waitReg(8'h90, 8'h00);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v & 8'hB1, 8'h00);
		// far end addresses the device, which acknowledges
		avAcc(1'h1, SMB_F_TX, 32'h5A);
		avAcc(1'h1, SMB_F_CMD, 32'h7);
		waitReg(8'h01, 8'h01);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v, 8'h29);
		check(link.scl, 1'h0);
		sfrGet(SMB_DATA_ADDR, SMB_SFR_PAGE, v); check(v, 8'h5A);
		setBit(SMB_B_ACK, 1'h1);
		setBit(SMB_B_SI, 1'h0);
		farIdle();
		check(q[2:0], 3'h2);
		waitReg(8'h11, 8'h11);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v & 8'hFD, 8'h31);
		// no acknowledge written: nack, then ignored until next start
		sfrPut(SMB_CTRL_ADDR, 1'h0, 3'h0, 8'h00);
		avAcc(1'h1, SMB_F_TX, 32'h3C);
		avAcc(1'h1, SMB_F_CMD, 32'h7);
		waitReg(8'h01, 8'h01);
		setBit(SMB_B_SI, 1'h0);
		farIdle();
		check(q[2:0], 3'h0);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v & 8'h19, 8'h00);
		// a fresh start is heard again
		avAcc(1'h1, SMB_F_CMD, 32'h7);
		waitReg(8'h09, 8'h09);
		sfrGet(SMB_CTRL_ADDR, SMB_SFR_PAGE, v); check(v & 8'h09, 8'h09);
		setBit(SMB_B_SI, 1'h0);
		farIdle();
		print_verdict();
	end
endmodule
